// ---- cpcc_params.svh ----
// Constants for the cluster power command block
`ifndef CPCC_PARAMS_SVH
`define CPCC_PARAMS_SVH
`define CPCC_NUM_CORES      6
`define CPCC_NUM_IO_COHERENCE_UNIT       2
`define CPCC_NUM_DOM        8
`define CPCC_CMD_LSB        0
`define CPCC_CMD_MSB        3
`define CPCC_CMD_CLOCK_GATED_COMMAND     4'h1
`define CPCC_CMD_PWROFF     4'h2
`define CPCC_CMD_PWRON      4'h3
`define CPCC_CMD_RESET      4'h4
`define CPCC_BASE_OFFSET    16'h0088
`define CPCC_BASE_EN_BIT    0
`define CPCC_BASE_MSB       47
`define CPCC_BASE_LSB       15
`define CPCC_BLK_GLOBAL     2'h0
`define CPCC_BLK_LOCAL      2'h1
`define CPCC_BLK_OTHER      2'h2
`define CPCC_CMD_OFFSET     13'h0000
`define CPCC_STAT_OFFSET    13'h0008
`define CPCC_STEP_CYCLES    4'h4
`endif

// ---- cpcc_pkg.sv ----
// Types for the cluster power command block
package cpcc_pkg;
	typedef enum logic [2:0] {
		CPCC_OFF     = 3'h0,
		CPCC_PWR     = 3'h1,
		CPCC_CLK     = 3'h3,
		CPCC_RST     = 3'h2,
		CPCC_ACTIVE  = 3'h6,
		CPCC_GATED   = 3'h7,
		CPCC_DOWN    = 3'h5
	} cpcc_state_t;
	typedef struct packed {
		cpcc_state_t state;
		logic [3:0]  cur_cmd;
		logic [3:0]  pend_cmd;
		logic        pend;
		logic [3:0]  cnt;
	} cpcc_dom_t;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [47:0] addr;
		logic [31:0] wdata;
		logic [2:0]  req_id;
		logic        req_io_coherence_unit;
	} cpcc_req_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} cpcc_rsp_t;
endpackage

// ---- cpcc_top.sv ----
// Per-domain power command sequencer with controller window decode
`include "cpcc_params.svh"
// Functional notes
// RULE1: Each domain has a command register; bits 3:0 written start a transition.
// RULE2: The coherence hub has no command register; only cores and IO units.
// RULE3: Code 1 gates clocks of an active non-coherent domain.
// RULE4: Code 1 on a powered-off domain powers up first, then gates clocks.
// RULE5: A clock-gated domain resumes operation on the power-on command.
// RULE6: Commands written during coherent mode wait until coherence drops.
// RULE7: Clock-gate or power-off during a sequence retargets the sequence; power-off still ends active, then the pending slot powers it off.
// RULE8: Code 2 powers the domain off.
// RULE9: Code 3 powers up, applies clocks and reset, ends operational.
// RULE10: Code 4 resets from active, off or gated; ends operational.
// RULE11: Offsets 0x0000-0x1FFF decode to the global block.
// RULE12: Offsets 0x2000-0x3FFF decode to the requester's own local block.
// RULE13: Offsets 0x4000-0x5FFF decode to another core's local block.
// RULE14: Requesters use aligned 32-bit uncached accesses only.
// RULE15: Window base is base register bits 47:15, low bits zero.
// RULE16: Base bit 0 enables decoding of the window.
// RULE17: Control state is kept separately for every domain.
// RULE18: Up to six cores and two IO units, each its own domain.
// RULE19: Unpopulated locations read zero; writes to them are dropped.
// RULE20: Writes from requesters without access privilege are ignored.
// RULE21: Requesters set the redirect target before using the core-other block.
// RULE22: Codes other than 1 to 4 change nothing.
// RULE23: Window hit needs enable set and address 47:15 equal to base.
module cpcc_top (
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_resetn,
	input  wire cpcc_pkg::cpcc_req_t          i_req,
	input  wire logic [7:0]                   i_access_en,
	input  wire logic [2:0]                   i_redirect,
	input  wire logic                         i_base_wr,
	input  wire logic [63:0]                  i_base_wdata,
	input  wire logic [7:0]                   i_coherent,
	output logic                              o_hit,
	output cpcc_pkg::cpcc_rsp_t               o_rsp,
	output logic [63:0]                       o_base,
	output logic [7:0]                        o_dom_power,
	output logic [7:0]                        o_dom_clock,
	output logic [7:0]                        o_dom_reset
);
	import cpcc_pkg::*;

	typedef struct packed {
		cpcc_dom_t [`CPCC_NUM_DOM-1:0] dom;
		logic [63:0]                   base;
		logic                          hit;
		cpcc_rsp_t                     rsp;
		logic [7:0]                    pwr;
		logic [7:0]                    clk;
		logic [7:0]                    rst;
	} cpcc_st_t;

	cpcc_st_t st_reg;
	cpcc_st_t st_next;

	// Domain index: cores 0..5, IO units 6..7
	function automatic logic [2:0] dom_index(input logic io_coherence_unit, input logic [2:0] id);
		dom_index = io_coherence_unit ? 3'(`CPCC_NUM_CORES + {2'h0, id[0]}) : id;
	endfunction

	function automatic logic window_hit(input logic [63:0] base, input logic [47:0] a);
		window_hit = base[`CPCC_BASE_EN_BIT]
			&& (a[`CPCC_BASE_MSB:`CPCC_BASE_LSB] == base[`CPCC_BASE_MSB:`CPCC_BASE_LSB]);
	endfunction

	function automatic logic is_stable(input cpcc_state_t s);
		is_stable = (s == CPCC_ACTIVE) || (s == CPCC_GATED) || (s == CPCC_DOWN);
	endfunction

	logic       hit_c;
	logic [1:0] blk;
	logic [2:0] req_dom;
	logic [2:0] tgt_dom;
	logic       tgt_ok;
	logic       priv_ok;
	logic [12:0] roff;

	always_comb begin
		hit_c   = window_hit(st_reg.base, i_req.addr); // RULE23 RULE15 RULE16
		blk     = i_req.addr[14:13];
		roff    = i_req.addr[12:0];
		req_dom = dom_index(i_req.req_io_coherence_unit, i_req.req_id);
		tgt_dom = req_dom; // RULE12
		tgt_ok  = i_req.req_io_coherence_unit ? 1'b1 : (i_req.req_id < 3'(`CPCC_NUM_CORES)); // RULE18
		if (blk == `CPCC_BLK_OTHER) begin
			tgt_dom = i_redirect; // RULE13 RULE21
			tgt_ok  = i_redirect < 3'(`CPCC_NUM_CORES);
		end
		priv_ok = i_access_en[req_dom]; // RULE20
	end

	always_comb begin
		st_next = st_reg;
		st_next.hit = i_req.valid && hit_c;
		st_next.rsp = '0;
		if (i_base_wr) begin
			st_next.base = {16'h0000, i_base_wdata[47:15], 14'h0000, i_base_wdata[0]}; // RULE15
		end
		for (int d = 0; d < `CPCC_NUM_DOM; d++) begin // RULE17
			if (st_reg.dom[d].pend && !i_coherent[d] && is_stable(st_reg.dom[d].state)) begin
				st_next.dom[d].pend    = 1'b0; // RULE6
				st_next.dom[d].cur_cmd = st_reg.dom[d].pend_cmd;
				st_next.dom[d].cnt     = `CPCC_STEP_CYCLES;
				unique case (st_reg.dom[d].pend_cmd)
					`CPCC_CMD_CLOCK_GATED_COMMAND: st_next.dom[d].state =
						(st_reg.dom[d].state == CPCC_DOWN) ? CPCC_PWR : CPCC_GATED; // RULE3 RULE4
					`CPCC_CMD_PWROFF: st_next.dom[d].state = CPCC_DOWN; // RULE8
					`CPCC_CMD_PWRON: st_next.dom[d].state =
						(st_reg.dom[d].state == CPCC_DOWN) ? CPCC_PWR : CPCC_ACTIVE; // RULE5 RULE9
					default: st_next.dom[d].state = CPCC_RST; // RULE10
				endcase
			end else if (!is_stable(st_reg.dom[d].state)) begin
				if (st_reg.dom[d].cnt != 4'h0) begin
					st_next.dom[d].cnt = st_reg.dom[d].cnt - 4'h1;
				end else begin
					st_next.dom[d].cnt = `CPCC_STEP_CYCLES;
					unique case (st_reg.dom[d].state)
						CPCC_PWR: st_next.dom[d].state = CPCC_CLK;
						CPCC_CLK: st_next.dom[d].state = CPCC_RST;
						default: st_next.dom[d].state =
							(st_reg.dom[d].cur_cmd == `CPCC_CMD_CLOCK_GATED_COMMAND) ? CPCC_GATED
							: CPCC_ACTIVE; // RULE4 RULE9 RULE10
					endcase
				end
			end
			// Outputs follow state; reset asserted only in the reset step
			st_next.pwr[d] = (st_next.dom[d].state != CPCC_DOWN)
				&& (st_next.dom[d].state != CPCC_OFF);
			st_next.clk[d] = (st_next.dom[d].state == CPCC_CLK)
				|| (st_next.dom[d].state == CPCC_RST) || (st_next.dom[d].state == CPCC_ACTIVE);
			st_next.rst[d] = (st_next.dom[d].state == CPCC_RST);
		end
		if (i_req.valid && hit_c) begin
			if ((blk == `CPCC_BLK_LOCAL || blk == `CPCC_BLK_OTHER) && tgt_ok) begin // RULE2
				if (i_req.write && priv_ok && roff == `CPCC_CMD_OFFSET) begin
					if (i_req.wdata[3:0] >= `CPCC_CMD_CLOCK_GATED_COMMAND
						&& i_req.wdata[3:0] <= `CPCC_CMD_RESET) begin // RULE22
						// Pending slot overwritten: newest target wins
						st_next.dom[tgt_dom].pend     = 1'b1; // RULE1 RULE7
						st_next.dom[tgt_dom].pend_cmd = i_req.wdata[`CPCC_CMD_MSB:`CPCC_CMD_LSB];
						if (!is_stable(st_reg.dom[tgt_dom].state)
							&& (i_req.wdata[3:0] == `CPCC_CMD_PWROFF
							|| i_req.wdata[3:0] == `CPCC_CMD_CLOCK_GATED_COMMAND)) begin
							st_next.dom[tgt_dom].cur_cmd = i_req.wdata[3:0]; // RULE7
						end
					end
				end
				if (!i_req.write) begin
					st_next.rsp.valid = 1'b1;
					if (roff == `CPCC_CMD_OFFSET) begin
						st_next.rsp.rdata = {28'h000_0000, st_reg.dom[tgt_dom].cur_cmd};
					end else if (roff == `CPCC_STAT_OFFSET) begin
						st_next.rsp.rdata = {24'h00_0000, 3'h0, st_reg.dom[tgt_dom].pend,
							1'b0, 3'(st_reg.dom[tgt_dom].state)};
					end
				end
			end else if (!i_req.write) begin
				st_next.rsp.valid = 1'b1; // RULE19 RULE11
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_hit       = st_reg.hit;
	assign o_rsp       = st_reg.rsp;
	assign o_base      = st_reg.base;
	assign o_dom_power = st_reg.pwr;
	assign o_dom_clock = st_reg.clk;
	assign o_dom_reset = st_reg.rst;

	// ============================================================
	// Checks
	property p_hit_needs_en;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(i_req.valid && !st_reg.base[0]) |=> !o_hit;
	endproperty
	a_hit_needs_en: assert property (p_hit_needs_en) else $error("hit while disabled"); // RULE16

	property p_hit_match;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		o_hit |-> $past(i_req.addr[47:15]) == $past(st_reg.base[47:15]);
	endproperty
	a_hit_match: assert property (p_hit_match) else $error("hit with wrong base"); // RULE23

	property p_base_low_zero;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		o_base[14:1] == 14'h0000;
	endproperty
	a_base_low_zero: assert property (p_base_low_zero) else $error("base low bits set"); // RULE15

	property p_coh_hold;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(st_reg.dom[1].pend && i_coherent[1]) |=> st_reg.dom[1].pend;
	endproperty
	a_coh_hold: assert property (p_coh_hold) else $error("command run while coherent"); // RULE6

	property p_off_no_power;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(st_reg.dom[0].state == CPCC_DOWN) |-> !o_dom_power[0];
	endproperty
	a_off_no_power: assert property (p_off_no_power) else $error("power while off"); // RULE8

	property p_gated_no_clk;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(st_reg.dom[0].state == CPCC_GATED) |-> (!o_dom_clock[0] && o_dom_power[0]);
	endproperty
	a_gated_no_clk: assert property (p_gated_no_clk) else $error("clock while gated"); // RULE3

	// ============================================================
	// Power-up walk, watched on the domain the bench sequences
	sequence s_powering;
		(st_reg.dom[0].state == CPCC_PWR) && o_dom_power[0] && !o_dom_clock[0];
	endsequence
	sequence s_clocking;
		(st_reg.dom[0].state == CPCC_CLK) && o_dom_clock[0] && !o_dom_reset[0];
	endsequence
	sequence s_resetting;
		(st_reg.dom[0].state == CPCC_RST) && o_dom_reset[0] && o_dom_clock[0];
	endsequence
	property p_up_order;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		$rose(st_reg.dom[0].state == CPCC_PWR)
		|-> s_powering ##[1:8] s_clocking ##[1:8] s_resetting;
	endproperty
	a_up_order: assert property (p_up_order) else $error("power-up stalled"); // RULE9

	// Reset step must end in a steady operational or gated state
	property p_rst_ends;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		$rose(st_reg.dom[0].state == CPCC_RST)
		|-> ##[1:8] (st_reg.dom[0].state == CPCC_ACTIVE || st_reg.dom[0].state == CPCC_GATED);
	endproperty
	a_rst_ends: assert property (p_rst_ends) else $error("reset step stuck"); // RULE10

	property p_bad_cmd;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(i_req.valid && i_req.write && i_req.wdata[3:0] > 4'h4 && !st_reg.dom[0].pend)
		|=> !st_reg.dom[0].pend;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("illegal code queued"); // RULE22

	property p_off_quiet;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(st_reg.dom[0].state == CPCC_DOWN) |-> (!o_dom_clock[0] && !o_dom_reset[0]);
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("clock or reset while off"); // RULE8

	// ============================================================
	// Register window answers
	property p_rsp_reads;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		o_rsp.valid |-> ($past(i_req.valid) && !$past(i_req.write) && $past(hit_c));
	endproperty
	a_rsp_reads: assert property (p_rsp_reads) else $error("answer without read"); // RULE19

	property p_global_zero;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(i_req.valid && !i_req.write && hit_c && blk == `CPCC_BLK_GLOBAL)
		|=> (o_rsp.valid && o_rsp.rdata == 32'h0000_0000);
	endproperty
	a_global_zero: assert property (p_global_zero) else $error("global read not zero"); // RULE11

	// Anything but the two populated words must read as zero
	property p_unpop_zero;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(i_req.valid && !i_req.write && hit_c
			&& roff != `CPCC_CMD_OFFSET && roff != `CPCC_STAT_OFFSET)
		|=> (o_rsp.rdata == 32'h0000_0000);
	endproperty
	a_unpop_zero: assert property (p_unpop_zero) else $error("unpopulated read not zero"); // RULE19

	property p_base_load;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		i_base_wr |=> (o_base[47:15] == $past(i_base_wdata[47:15])
			&& o_base[0] == $past(i_base_wdata[0]) && o_base[63:48] == 16'h0000);
	endproperty
	a_base_load: assert property (p_base_load) else $error("base load wrong"); // RULE15

	// ============================================================
	// Command acceptance
	property p_no_priv;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(i_req.valid && i_req.write && hit_c && !i_req.req_io_coherence_unit && i_req.req_id == 3'h2
			&& blk == `CPCC_BLK_LOCAL && !i_access_en[2] && !st_reg.dom[2].pend)
		|=> !st_reg.dom[2].pend;
	endproperty
	a_no_priv: assert property (p_no_priv) else $error("unprivileged write queued"); // RULE20

	// Retarget must land on the cycle after the write, or the old target completes
	property p_retarget;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(i_req.valid && i_req.write && hit_c && !i_req.req_io_coherence_unit && i_req.req_id == 3'h0
			&& blk == `CPCC_BLK_LOCAL && i_access_en[0] && !is_stable(st_reg.dom[0].state)
			&& i_req.wdata[3:0] == `CPCC_CMD_PWROFF)
		|=> (st_reg.dom[0].cur_cmd == `CPCC_CMD_PWROFF);
	endproperty
	a_retarget: assert property (p_retarget) else $error("retarget not taken"); // RULE7

	property p_coh_release;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(st_reg.dom[1].pend && !i_coherent[1] && is_stable(st_reg.dom[1].state) && !i_req.valid)
		|=> !st_reg.dom[1].pend;
	endproperty
	a_coh_release: assert property (p_coh_release) else $error("pending not released"); // RULE6

	// IO unit 1 owns the last domain slot
	property p_io_coherence_unit_slot;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(i_req.valid && i_req.write && hit_c && i_req.req_io_coherence_unit && i_req.req_id[0]
			&& blk == `CPCC_BLK_LOCAL && i_access_en[7]
			&& i_req.wdata[3:0] == `CPCC_CMD_PWRON)
		|=> (st_reg.dom[7].pend && st_reg.dom[7].pend_cmd == `CPCC_CMD_PWRON);
	endproperty
	a_io_coherence_unit_slot: assert property (p_io_coherence_unit_slot) else $error("io unit write misrouted"); // RULE18
endmodule // cpcc_top

// ---- cpcc_req_model.sv ----
// Requester model: a core or IO unit issuing controller register accesses
module cpcc_req_model
	import cpcc_pkg::*;
(
	input  wire logic      i_clk_sys,
	input  wire logic      i_hit,
	input  wire cpcc_rsp_t i_rsp,
	output cpcc_req_t      o_req
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        hit_seen;
	logic [31:0] rdata_seen;
	initial o_req = '0;
	// ==========================================
	// Single-word access
	task automatic access(input logic wr, input logic [47:0] a, input logic [31:0] d,
		input logic [2:0] id, input logic io);
		@(posedge i_clk_sys);
		o_req <= '{1'b1, wr, {a[47:2], 2'b00}, d, id, io};
		@(posedge i_clk_sys);
		o_req.valid <= 1'b0;
		// Released lines do not keep the old value
		o_req.addr  <= ~a;
		o_req.wdata <= ~d;
		#1;
		hit_seen   = i_hit;
		rdata_seen = i_rsp.valid ? i_rsp.rdata : 32'hDEAD_BEEF;
	endtask
endmodule // cpcc_req_model

// ---- tb.sv ----
// Self-checking bench for the cluster power command block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cpcc_pkg::*;
	localparam logic [47:0] WIN = 48'h0000_1BDE_0000;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  access_en = 8'hFF;
	logic [2:0]  redirect = 3'h0;
	logic        base_wr = 1'b0;
	logic [63:0] base_wdata = 64'h0;
	logic [7:0]  coherent = 8'h00;
	cpcc_req_t   req;
	cpcc_rsp_t   rsp;
	logic        hit;
	logic [63:0] base;
	logic [7:0]  pwr;
	logic [7:0]  clkd;
	logic [7:0]  rstd;
	int          n_fail = 0;
	int          cmp_count = 0;
	always #10 clk = ~clk;
	cpcc_top cpcc_top_i (.i_clk_sys(clk), .i_resetn(resetn), .i_req(req),
		.i_access_en(access_en), .i_redirect(redirect), .i_base_wr(base_wr),
		.i_base_wdata(base_wdata), .i_coherent(coherent), .o_hit(hit), .o_rsp(rsp),
		.o_base(base), .o_dom_power(pwr), .o_dom_clock(clkd), .o_dom_reset(rstd));
	cpcc_req_model cpcc_req_model_i (.i_clk_sys(clk), .i_hit(hit), .i_rsp(rsp), .o_req(req));
	// ==========================================
	// Access and compare tasks
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [15:0] off, input logic [31:0] d, input logic [2:0] id,
		input logic io);
		cpcc_req_model_i.access(1'b1, WIN + {32'h0, off}, d, id, io);
	endtask
	task automatic rd(input logic [15:0] off, input logic [2:0] id, input logic io);
		cpcc_req_model_i.access(1'b0, WIN + {32'h0, off}, 32'h0, id, io);
	endtask
	task automatic setb(input logic [63:0] d);
		@(posedge clk);
		base_wr    <= 1'b1;
		base_wdata <= d;
		@(posedge clk);
		base_wr <= 1'b0;
		#1;
	endtask
	// Polls status until settled; bounded so a stuck domain still reports
	task automatic st(input logic [15:0] blk, input logic [2:0] id, input logic io,
		input cpcc_state_t s, input string nm);
		for (int i = 0; i < 40; i++) begin
			rd(blk + 16'h0008, id, io);
			if (cpcc_req_model_i.rdata_seen[2:0] === s && cpcc_req_model_i.rdata_seen[4] === 1'b0)
				break;
		end
		check(nm, {cpcc_req_model_i.rdata_seen[4], cpcc_req_model_i.rdata_seen[2:0]}, {1'b0, s});
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		complete_run();
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [3:0]  codes [5] = '{4'h1, 4'h3, 4'h2, 4'h1, 4'h4};
		cpcc_state_t sts [5]   = '{CPCC_GATED, CPCC_ACTIVE, CPCC_DOWN, CPCC_GATED, CPCC_ACTIVE};
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		#1 check("power_after_reset", pwr, 8'h00);
		setb(64'hFFFF_0000_1BDE_7FFF);
		check("base", base, 64'h0000_1BDE_0001);
		rd(16'h0100, 3'h0, 1'b0);
		check("global_rd", cpcc_req_model_i.rdata_seen, 32'h0);
		rd(16'h2010, 3'h0, 1'b0);
		check("unpop_rd", cpcc_req_model_i.rdata_seen, 32'h0);
		cpcc_req_model_i.access(1'b0, 48'h0000_1BDE_8008, 32'h0, 3'h0, 1'b0);
		check("miss_hit", cpcc_req_model_i.hit_seen, 1'b0);
		wr(16'h2000, 32'h0000_0003, 3'h0, 1'b0);
		check("local_hit", cpcc_req_model_i.hit_seen, 1'b1);
		st(16'h2000, 3'h0, 1'b0, CPCC_ACTIVE, "pwron");
		for (int k = 0; k < 5; k++) begin
			wr(16'h2000, {28'h0, codes[k]}, 3'h0, 1'b0);
			st(16'h2000, 3'h0, 1'b0, sts[k], "cmd_seq");
			check("levels", {pwr[0], clkd[0], rstd[0]},
				{sts[k] != CPCC_DOWN, sts[k] == CPCC_ACTIVE, 1'b0});
		end
		wr(16'h2000, 32'h0000_0009, 3'h0, 1'b0);
		st(16'h2000, 3'h0, 1'b0, CPCC_ACTIVE, "illegal");
		wr(16'h2000, 32'h0000_0004, 3'h0, 1'b0);
		wr(16'h2000, 32'h0000_0002, 3'h0, 1'b0);
		st(16'h2000, 3'h0, 1'b0, CPCC_DOWN, "retarget");
		redirect <= 3'h1;
		coherent <= 8'h02;
		wr(16'h4000, 32'h0000_0003, 3'h0, 1'b0);
		repeat (20) @(posedge clk);
		rd(16'h4008, 3'h0, 1'b0);
		check("pending", cpcc_req_model_i.rdata_seen[4], 1'b1);
		coherent <= 8'h00;
		st(16'h4000, 3'h0, 1'b0, CPCC_ACTIVE, "other_blk");
		wr(16'h2000, 32'h0000_0002, 3'h2, 1'b0);
		st(16'h2000, 3'h2, 1'b0, CPCC_DOWN, "dom2_off");
		access_en <= 8'hFB;
		wr(16'h2000, 32'h0000_0003, 3'h2, 1'b0);
		repeat (20) @(posedge clk);
		rd(16'h2008, 3'h2, 1'b0);
		check("no_priv", {cpcc_req_model_i.rdata_seen[4], pwr[2]}, 2'b00);
		access_en <= 8'hFF;
		wr(16'h2000, 32'h0000_0003, 3'h1, 1'b1);
		st(16'h2000, 3'h1, 1'b1, CPCC_ACTIVE, "io_coherence_unit");
		check("io_coherence_unit_pwr", pwr[7], 1'b1);
		setb(64'h0000_1BDE_0000);
		rd(16'h2008, 3'h0, 1'b0);
		check("disabled", cpcc_req_model_i.hit_seen, 1'b0);
		complete_run();
	end
endmodule // tb
